/* File: pkg/ntpc_defines.vh */
// Constants of the disciplined timestamp clock: offsets, fields, resets, timing.
// Assumes a single 125 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef NTPC_DEFINES_VH
`define NTPC_DEFINES_VH
// Register byte offsets
`define NTPC_CTRL_OFF       8'h00
`define NTPC_SERVER_IP_OFF  8'h04
`define NTPC_CLIENT_IP_OFF  8'h08
`define NTPC_MAX_LOG_OFF    8'h0c
`define NTPC_STATUS_OFF     8'h10
`define NTPC_TIME_SEC_OFF   8'h14
`define NTPC_TIME_FRAC_OFF  8'h18
`define NTPC_OFFSET_OFF     8'h1c
// Fields
`define NTPC_CTRL_EN_BIT    0
`define NTPC_ST_CFG_OK_BIT  0
`define NTPC_ST_SET_BIT     1
`define NTPC_ST_SYNC_BIT    2
// Reset values
`define NTPC_CTRL_RST       32'h0000_0000
`define NTPC_IP_RST         32'h0000_0000
`define NTPC_MAX_LOG_RST    4'h9
// Timing
`define NTPC_CLK_HZ         125000000
`define NTPC_CLK_NS         8
`define NTPC_RETRY_S        1
`define NTPC_SEC_CYCLES     (`NTPC_RETRY_S * `NTPC_CLK_HZ)
`define NTPC_MIN_LOG        4'h4
`define NTPC_MAX_LOG        4'h9
`define NTPC_BURST_LEN      4'h8
// Offset limits in microseconds and in 2^-32 s units
`define NTPC_UP_LIMIT_US    100
`define NTPC_DOWN_LIMIT_US  50
`define NTPC_UP_LIMIT  ((48'd4294967296 * `NTPC_UP_LIMIT_US) / 48'd1000000)
`define NTPC_DOWN_LIMIT ((48'd4294967296 * `NTPC_DOWN_LIMIT_US) / 48'd1000000)
// Nominal increment per cycle, 2^-64 s units
`define NTPC_NOM_INC   ({1'b1, 64'h0} / 65'd125000000)
// FILETIME: 100 ns units since 1601, NTP seconds since 1900
`define NTPC_FT_UNIT_NS     100
`define NTPC_FT_PER_S       (64'd1000000000 / `NTPC_FT_UNIT_NS)
`define NTPC_EPOCH_S        64'd9435484800
`endif

/* File: rtl/ntpc_clock.v */
// NTP-disciplined time-of-day counter with FILETIME frame stamps.
// Assumes a network engine that performs exchanges and reports offset and delay.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ntpc_defines.vh"
module ntpc_clock #(
  parameter SEC_CYCLES = `NTPC_SEC_CYCLES
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Network engine settings
  output reg  [31:0] server_ip,
  output reg  [31:0] client_ip,
  // Initial time request
  output reg         init_req,
  input  wire        init_done,
  input  wire        init_fail,
  input  wire [63:0] init_time,
  // Exchange request and result
  output reg         exch_req,
  input  wire        exch_done,
  input  wire        exch_fail,
  input  wire [47:0] exch_offset,
  input  wire [31:0] exch_rtt,
  // Frame stamp
  input  wire        frame_strobe,
  output reg  [31:0] stamp_word,
  output reg         stamp_word_valid,
  output reg         stamp_high_word
);
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_INIT  = 8'h02;
  localparam [7:0] ST_IWAIT = 8'h04;
  localparam [7:0] ST_RETRY = 8'h08;
  localparam [7:0] ST_PER   = 8'h10;
  localparam [7:0] ST_EXCH  = 8'h20;
  localparam [7:0] ST_EWAIT = 8'h40;
  localparam [7:0] ST_ADJ   = 8'h80;
  localparam [64:0] NOM_INC = `NTPC_NOM_INC;
  localparam [47:0] UP_LIM  = `NTPC_UP_LIMIT;
  localparam [47:0] DN_LIM  = `NTPC_DOWN_LIMIT;

  reg         [31:0] ctrl;
  reg         [3:0]  max_log;
  reg         [7:0]  state;
  reg         [95:0] tod;
  reg                time_set;
  reg         [31:0] sec_div;
  reg         [9:0]  sec_cnt;
  reg         [3:0]  plog;
  reg         [3:0]  burst_cnt;
  reg         [31:0] best_rtt;
  reg  signed [47:0] best_off;
  reg                best_ok;
  reg  signed [47:0] filt;
  reg  signed [47:0] drift;
  reg  signed [47:0] adj;
  reg         [63:0] stamp_cap;
  reg                stamp_busy;
  reg         [7:0]  aw_addr;
  reg                aw_have;
  reg         [31:0] w_data;
  reg         [3:0]  w_strb;
  reg                w_have;
  reg         [63:0] rd_time;

  wire        cfg_ok = (server_ip != 32'h0) && (client_ip != 32'h0) && (server_ip != client_ip)
                       && (max_log >= `NTPC_MIN_LOG) && (max_log <= `NTPC_MAX_LOG);
  wire        run    = ctrl[`NTPC_CTRL_EN_BIT];
  wire        sec_tick = (sec_div == SEC_CYCLES - 1);
  wire [47:0] abs_off = best_off[47] ? (48'h0 - best_off) : best_off;
  wire [3:0]  lim_log = (max_log > `NTPC_MAX_LOG) ? `NTPC_MAX_LOG : max_log;
  wire signed [47:0] next_filt = filt + ((best_off - filt) >>> 3);
  wire signed [47:0] next_adj  = (next_filt <<< 5) >>> plog;
  wire [64:0] inc_sum = NOM_INC + {{17{drift[47]}}, drift} + {{17{adj[47]}}, adj};
  wire [63:0] ft_sec  = ({32'h0, stamp_cap[63:32]} + `NTPC_EPOCH_S) * `NTPC_FT_PER_S;
  wire [63:0] ft_prod = {32'h0, stamp_cap[31:0]} * `NTPC_FT_PER_S;
  wire [63:0] filetime = ft_sec + {32'h0, ft_prod[63:32]};

  // Clock counter: rate steered, value loaded only once
  always @(posedge aclk) begin
    if (!aresetn) begin
      tod      <= 96'h0;
      time_set <= 1'b0;
    end else if (state == ST_IWAIT && init_done && !time_set) begin
      tod      <= {init_time, 32'h0};
      time_set <= 1'b1;
    end else if (time_set) begin
      tod <= tod + {31'h0, inc_sum};
    end
  end

  // Sync sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_IDLE;
      sec_div   <= 32'h0;
      sec_cnt   <= 10'h0;
      plog      <= `NTPC_MIN_LOG;
      burst_cnt <= 4'h0;
      best_rtt  <= 32'hffff_ffff;
      best_off  <= 48'h0;
      best_ok   <= 1'b0;
      filt      <= 48'h0;
      drift     <= 48'h0;
      adj       <= 48'h0;
      init_req  <= 1'b0;
      exch_req  <= 1'b0;
    end else begin
      init_req <= 1'b0;
      exch_req <= 1'b0;
      sec_div  <= sec_tick ? 32'h0 : sec_div + 32'h1;
      if (sec_tick) begin
        sec_cnt <= sec_cnt + 10'h1;
      end
      case (state)
        ST_IDLE: begin
          if (run && cfg_ok) begin
            state    <= time_set ? ST_PER : ST_INIT;
            sec_div  <= 32'h0;
            sec_cnt  <= 10'h0;
          end
        end
        ST_INIT: begin
          init_req <= 1'b1;
          state    <= ST_IWAIT;
        end
        ST_IWAIT: begin
          if (init_done) begin
            state   <= ST_PER;
            sec_div <= 32'h0;
            sec_cnt <= 10'h0;
          end else if (init_fail) begin
            state   <= ST_RETRY;
            sec_div <= 32'h0;
          end
        end
        ST_RETRY: begin
          if (sec_tick) begin
            state <= ST_INIT;
          end
        end
        ST_PER: begin
          if (!run || !cfg_ok) begin
            state <= ST_IDLE;
          end else if (sec_cnt >= (10'h1 << plog)) begin
            state     <= ST_EXCH;
            burst_cnt <= 4'h0;
            best_rtt  <= 32'hffff_ffff;
            best_ok   <= 1'b0;
          end
        end
        ST_EXCH: begin
          exch_req <= 1'b1;
          state    <= ST_EWAIT;
        end
        ST_EWAIT: begin
          if (exch_done || exch_fail) begin
            if (exch_done && exch_rtt < best_rtt) begin
              best_rtt <= exch_rtt;
              best_off <= exch_offset;
              best_ok  <= 1'b1;
            end
            burst_cnt <= burst_cnt + 4'h1;
            state <= (burst_cnt == `NTPC_BURST_LEN - 4'h1) ? ST_ADJ : ST_EXCH;
          end
        end
        ST_ADJ: begin
          if (best_ok) begin
            filt  <= next_filt;
            adj   <= next_adj;
            drift <= drift + (next_adj >>> 4);
            if (abs_off > DN_LIM) begin
              plog <= `NTPC_MIN_LOG;
            end else if (abs_off < UP_LIM || plog >= lim_log) begin
              plog <= (plog >= lim_log) ? lim_log : plog + 4'h1;
            end
          end
          state   <= ST_PER;
          sec_div <= 32'h0;
          sec_cnt <= 10'h0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Frame stamp: low word then high word
  always @(posedge aclk) begin
    if (!aresetn) begin
      stamp_cap        <= 64'h0;
      stamp_busy       <= 1'b0;
      stamp_word       <= 32'h0;
      stamp_word_valid <= 1'b0;
      stamp_high_word  <= 1'b0;
    end else begin
      stamp_word_valid <= 1'b0;
      stamp_high_word  <= 1'b0;
      if (!stamp_busy && frame_strobe) begin
        stamp_cap  <= tod[95:32];
        stamp_busy <= 1'b1;
      end else if (stamp_busy && !stamp_word_valid) begin
        stamp_word       <= filetime[31:0];
        stamp_word_valid <= 1'b1;
      end else if (stamp_busy) begin
        stamp_word       <= filetime[63:32];
        stamp_word_valid <= 1'b1;
        stamp_high_word  <= 1'b1;
        stamp_busy       <= 1'b0;
      end
    end
  end

  // AXI4-Lite write side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      ctrl          <= `NTPC_CTRL_RST;
      server_ip     <= `NTPC_IP_RST;
      client_ip     <= `NTPC_IP_RST;
      max_log       <= `NTPC_MAX_LOG_RST;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_have && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case ({aw_addr[7:2], 2'b00})
          `NTPC_CTRL_OFF: if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
          `NTPC_SERVER_IP_OFF: server_ip <= w_strb[3] ? w_data : server_ip;
          `NTPC_CLIENT_IP_OFF: client_ip <= w_strb[3] ? w_data : client_ip;
          `NTPC_MAX_LOG_OFF: if (w_strb[0]) max_log <= w_data[3:0];
          `NTPC_STATUS_OFF, `NTPC_TIME_SEC_OFF, `NTPC_TIME_FRAC_OFF,
          `NTPC_OFFSET_OFF: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end

  // AXI4-Lite read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
      rd_time       <= 64'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case ({s_axi_araddr[7:2], 2'b00})
          `NTPC_CTRL_OFF:      s_axi_rdata <= ctrl;
          `NTPC_SERVER_IP_OFF: s_axi_rdata <= server_ip;
          `NTPC_CLIENT_IP_OFF: s_axi_rdata <= client_ip;
          `NTPC_MAX_LOG_OFF:   s_axi_rdata <= {28'h0, max_log};
          `NTPC_STATUS_OFF:    s_axi_rdata <= {20'h0, plog, 5'h0,
                                               (state == ST_PER), time_set, cfg_ok};
          `NTPC_TIME_SEC_OFF: begin
            s_axi_rdata <= tod[95:64];
            rd_time     <= tod[95:32];
          end
          `NTPC_TIME_FRAC_OFF: s_axi_rdata <= rd_time[31:0];
          `NTPC_OFFSET_OFF:    s_axi_rdata <= best_off[31:0];
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule // ntpc_clock

/* File: dv/ntpc_clock_props.sv */
// Port checker for the disciplined timestamp clock.
// Assumes a bind into ntpc_clock; reset is synchronous, active low.
`timescale 1ns/1ps
module ntpc_clock_props #(
  parameter SEC_CYCLES = 20
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus answers
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Engine link
  input wire logic       init_req,
  input wire logic       init_done,
  input wire logic       init_fail,
  input wire logic       exch_req,
  // Frame stamp
  input wire logic       frame_strobe,
  input wire logic       stamp_word_valid,
  input wire logic       stamp_high_word
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        time_set;
  logic [31:0] since_fail;
  // Time loaded flag, cycles since a failed attempt
  always @(posedge aclk) begin
    if (!aresetn) begin
      time_set   <= 1'b0;
      since_fail <= 32'h0;
    end else begin
      if (init_done) time_set <= 1'b1;
      if (init_fail) since_fail <= 32'h1;
      else if (init_req) since_fail <= 32'h0;
      else if (since_fail != 32'h0) since_fail <= since_fail + 32'h1;
    end
  end
  sequence s_low; stamp_word_valid && !stamp_high_word; endsequence
  sequence s_high; stamp_word_valid && stamp_high_word; endsequence
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_no_early_sync: assert property (!time_set |-> !exch_req)
    else $error("exchange before time loaded");
  chk_retry_gap: assert property (init_req && since_fail != 32'h0 |->
    since_fail == SEC_CYCLES + 2) else $error("retry spacing wrong");
  chk_retry_due: assert property (since_fail <= SEC_CYCLES + 2)
    else $error("retry missing");
  chk_stamp_pair: assert property (s_low |=> s_high)
    else $error("high word missing");
  chk_stamp_lead: assert property (s_low |-> $past(frame_strobe, 2))
    else $error("low word not tied to strobe");
  chk_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !init_req && !exch_req && !stamp_word_valid)
    else $error("output active after reset");
endmodule // ntpc_clock_props
bind ntpc_clock ntpc_clock_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .init_req,
  .init_done, .init_fail, .exch_req, .frame_strobe, .stamp_word_valid, .stamp_high_word);

/* File: dv/ntpc_engine_model.sv */
// Behavioural time server engine facing the timestamp clock.
// Assumes one-cycle request pulses; answers after lat cycles.
`timescale 1ns/1ps
module ntpc_engine_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Scenario controls
  input  wire logic [3:0]  init_fails,
  input  wire logic [3:0]  lat,
  input  wire logic [47:0] best_off,
  input  wire logic [63:0] init_val,
  // Requests
  input  wire logic        init_req,
  input  wire logic        exch_req,
  // Answers
  output logic             init_done,
  output logic             init_fail,
  output logic [63:0]      init_time,
  output logic             exch_done,
  output logic             exch_fail,
  output logic [47:0]      exch_offset,
  output logic [31:0]      exch_rtt
);
  logic [3:0] wait_i, wait_e, fails_left, idx;
  always @(posedge aclk) begin
    init_done   <= 1'b0;
    init_fail   <= 1'b0;
    exch_done   <= 1'b0;
    exch_fail   <= 1'b0;
    // Stale result lines keep changing
    init_time   <= ~init_time;
    exch_offset <= ~exch_offset;
    exch_rtt    <= ~exch_rtt;
    if (!aresetn) begin
      {wait_i, wait_e, idx} <= 12'h0;
      fails_left  <= init_fails;
      {init_time, exch_offset, exch_rtt} <= 144'h0;
    end else begin
      if (init_req) wait_i <= lat;
      else if (wait_i != 4'h0) wait_i <= wait_i - 4'h1;
      if (wait_i == 4'h1 && !init_req) begin
        init_fail <= (fails_left != 4'h0);
        init_done <= (fails_left == 4'h0);
        init_time <= init_val;
        if (fails_left != 4'h0) fails_left <= fails_left - 4'h1;
      end
      if (exch_req) wait_e <= lat;
      else if (wait_e != 4'h0) wait_e <= wait_e - 4'h1;
      // Exchange five has the shortest valid round trip; exchange three fails
      if (wait_e == 4'h1 && !exch_req) begin
        exch_done   <= (idx != 4'h3);
        exch_fail   <= (idx == 4'h3);
        exch_rtt    <= (idx == 4'h5) ? 32'h0a : (idx == 4'h3) ? 32'h01 : 32'h64 + {28'h0, idx};
        exch_offset <= (idx == 4'h5) ? best_off : 48'hd_1b71;
        idx         <= (idx == 4'h7) ? 4'h0 : idx + 4'h1;
      end
    end
  end
endmodule // ntpc_engine_model

/* File: dv/ntp_disciplined_timestamp_clock_tb.sv */
// Testbench for the disciplined timestamp clock.
// Assumes ntpc_clock, the engine model and the checker bind.
`timescale 1ns/1ps
`include "ntpc_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ntp_disciplined_timestamp_clock_tb;
  localparam SEC = 20;
  logic        aclk = 1'b0, aresetn = 1'b0, frame_strobe = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0]  s_axi_wstrb = 4'hf, init_fails = 4'h1, lat = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [47:0] best_off = 48'ha7c6;
  logic [63:0] init_val = {32'he000_0000, 32'h0}, ft0, ft1, ft2;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, server_ip, client_ip, stamp_word, exch_rtt;
  wire         init_req, init_done, init_fail, exch_req, exch_done, exch_fail;
  wire         stamp_word_valid, stamp_high_word;
  wire  [63:0] init_time;
  wire  [47:0] exch_offset;
  int          num_errors = 0, checks_done = 0, cyc = 0, n_exch = 0, n_init = 0, t_load;
  ntpc_clock #(.SEC_CYCLES(SEC)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .server_ip, .client_ip, .init_req, .init_done,
    .init_fail, .init_time, .exch_req, .exch_done, .exch_fail, .exch_offset, .exch_rtt,
    .frame_strobe, .stamp_word, .stamp_word_valid, .stamp_high_word);
  ntpc_engine_model engine (.aclk, .aresetn, .init_fails, .lat, .best_off, .init_val,
    .init_req, .exch_req, .init_done, .init_fail, .init_time, .exch_done, .exch_fail,
    .exch_offset, .exch_rtt);
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc    <= cyc + 1;
    n_exch <= n_exch + int'(exch_req);
    n_init <= n_init + int'(init_req);
    if (cyc == 8000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        {v, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic t_regs();
    axr(`NTPC_MAX_LOG_OFF, d, r);
    `CHK(d[3:0], 4'h9)
    axr(8'h20, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    axw(8'h20, 32'h1, r);
    `CHK(r, 2'b10)
    axw(`NTPC_STATUS_OFF, 32'h7, r);
    `CHK(r, 2'b00)
    axw(`NTPC_MAX_LOG_OFF, 32'h5, r);
    axw(`NTPC_CTRL_OFF, 32'h1, r);
    repeat (40) @(posedge aclk);
    `CHK(n_init, 0)
    axr(`NTPC_STATUS_OFF, d, r);
    `CHK(d[0], 1'b0)
    axw(`NTPC_SERVER_IP_OFF, 32'h0a00_0001, r);
    `CHK(server_ip, 32'h0a00_0001)
    axw(`NTPC_CLIENT_IP_OFF, 32'h0a00_0002, r);
    `CHK(client_ip, 32'h0a00_0002)
  endtask
  task automatic t_start();
    int t;
    while (!init_fail) @(posedge aclk);
    t = cyc;
    while (!init_req) @(posedge aclk);
    `CHK(cyc - t, SEC + 2)
    while (!init_done) @(posedge aclk);
    t_load = cyc;
    `CHK(n_exch, 0)
    axr(`NTPC_STATUS_OFF, d, r);
    `CHK(d[11:8], 4'h4)
  endtask
  task automatic stamp(output logic [63:0] ft);
    @(posedge aclk);
    frame_strobe <= 1'b1;
    @(posedge aclk);
    frame_strobe <= 1'b0;
    while (!(stamp_word_valid && !stamp_high_word)) @(posedge aclk);
    ft[31:0] = stamp_word;
    @(posedge aclk);
    `CHK({stamp_word_valid, stamp_high_word}, 2'b11)
    ft[63:32] = stamp_word;
  endtask
  task automatic t_stamps();
    logic [63:0] e;
    stamp(ft1);
    ft0 = (64'he000_0000 + `NTPC_EPOCH_S) * 64'd10000000;
    e = 64'(cyc - t_load) * 64'd8 / 64'd100;
    `CHK((ft1 - ft0 + 64'd3 > e) && (ft1 - ft0 < e + 64'd3), 1'b1)
    stamp(ft2);
    `CHK((ft2 >= ft1) && (ft2 - ft1 < 64'd2), 1'b1)
    axr(`NTPC_TIME_SEC_OFF, d, r);
    `CHK(d, 32'he000_0000)
    axr(`NTPC_TIME_FRAC_OFF, d, r);
    `CHK((d > 32'(cyc - t_load - 8) * 32'd34) && (d < 32'(cyc - t_load) * 32'd35), 1'b1)
  endtask
  task automatic t_burst(input logic [47:0] off, input logic [3:0] l, input logic [3:0] pl);
    int n0;
    best_off <= off;
    lat <= l;
    n0 = n_exch;
    while (n_exch == n0) @(posedge aclk);
    repeat (150) @(posedge aclk);
    `CHK(n_exch - n0, 8)
    axr(`NTPC_STATUS_OFF, d, r);
    `CHK(d[11:8], pl)
    axr(`NTPC_OFFSET_OFF, d, r);
    `CHK(d, off[31:0])
  endtask
  task automatic t_pause();
    int n0;
    n0 = n_init;
    axw(`NTPC_CTRL_OFF, 32'h0, r);
    repeat (4) @(posedge aclk);
    axr(`NTPC_STATUS_OFF, d, r);
    `CHK(d[2:0], 3'b011)
    axw(`NTPC_CTRL_OFF, 32'h1, r);
    repeat (4) @(posedge aclk);
    axr(`NTPC_STATUS_OFF, d, r);
    `CHK(d[2:0], 3'b111)
    `CHK(n_init, n0)
  endtask
  task automatic end_sim();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_start();
    t_stamps();
    t_burst(48'ha7c6, 4'h1, 4'h5);
    t_burst(48'ha7c6, 4'h6, 4'h5);
    t_burst(48'h5_0000, 4'h1, 4'h4);
    t_burst(48'hffff_ffff_583a, 4'h2, 4'h5);
    t_pause();
    end_sim();
  end
endmodule // ntp_disciplined_timestamp_clock_tb
